//--- src/ssld_pkg.sv
// shared constants of the serial shift latch driver
package ssld_pkg;

    // width of the shift, storage and output stages
    localparam int unsigned CHANNELS = 8;

    // index of the stage that takes the serial input
    localparam int unsigned FIRST_STAGE = 0;

    // index of the stage that feeds the cascade output
    localparam int unsigned LAST_STAGE = CHANNELS - 1;

    // flip-flops in every synchroniser chain
    localparam int unsigned SYNC_STAGES = 2;

    // clk cycles the synchronised word must hold still before capture
    localparam int unsigned SETTLE_CYCLES = 2;

    // entries of the buffer between capture and storage
    localparam int unsigned BUF_DEPTH = 2;

    // values after reset and after a clear
    localparam logic [CHANNELS-1:0] SHIFT_RESET   = 8'h00;
    localparam logic [CHANNELS-1:0] STORE_RESET   = 8'h00;
    localparam logic [CHANNELS-1:0] CHANNEL_RESET = 8'h00;
    localparam logic                CASCADE_RESET = 1'h0;

    // capture sequence states
    typedef enum logic [1:0] {
        SSLD_IDLE   = 2'b00,
        SSLD_SETTLE = 2'b01,
        SSLD_PUSH   = 2'b10
    } ssld_cap_state_t;

endpackage

//--- src/ssld_sync.sv
// two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module ssld_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // first stage is read only by the second stage
    always_comb begin
        next_meta     = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end

endmodule

//--- src/ssld_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ssld_buf2 #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr, next_wr_ptr;
    logic [PW-1:0]    rd_ptr, next_rd_ptr;
    logic [CW-1:0]    count, next_count;
    logic             push, pop;

    // honest full and empty straight from the fill count
    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update, flush drops everything
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end else begin
            if (push) begin
                next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
            end
            next_count = count + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage cells need no reset, they are only read when valid
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

//--- src/ssld_top.sv
// serial shift latch driver: shift stage, storage stage, gated channels
`timescale 1ns/1ps
module ssld_top #(
    parameter int unsigned CHANNELS = ssld_pkg::CHANNELS
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                shift_clock,
    input  wire logic                serial_in,
    input  wire logic                storage_clock,
    input  wire logic                clear_n,
    input  wire logic                output_enable_n,
    output logic                     cascade_out,
    output logic      [CHANNELS-1:0] channel_sink,
    output logic      [CHANNELS-1:0] channel_sink_out,
    output logic      [CHANNELS-1:0] channel_sink_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // link domain: shift register on the host's shift clock
    ////////////////////////////////////////////////////////////////////////

    logic                link_rst_n;
    logic [CHANNELS-1:0] shift_reg;
    logic [CHANNELS-1:0] next_shift_reg;
    logic                next_cascade_out;

    // either reset source empties the link side at once
    // release is not aligned to shift_clock; the host keeps that clock still then
    assign link_rst_n = clear_n & rstn;

    // serial_in lands in stage 0, older bits move up
    always_comb begin
        next_shift_reg = {shift_reg[CHANNELS-2:0], serial_in};
    end

    // one stage per rising edge; no edge, no change
    always_ff @(posedge shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift_reg <= ssld_pkg::SHIFT_RESET;
        end else begin
            shift_reg <= next_shift_reg;
        end
    end

    // last stage drives the chain pin
    always_comb begin
        next_cascade_out = shift_reg[ssld_pkg::LAST_STAGE];
    end

    // falling edge gives the next device half a period of hold
    always_ff @(negedge shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cascade_out <= ssld_pkg::CASCADE_RESET;
        end else begin
            cascade_out <= next_cascade_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossing into the system clock domain
    ////////////////////////////////////////////////////////////////////////

    logic                store_clk_s;
    logic                clear_s_n;
    logic                oe_s_n;
    logic [CHANNELS-1:0] word_s;

    // pins as seen in reset: storage low, outputs disabled, clear asserted
    localparam logic [2:0] CTRL_RESET = {1'h0, 1'h1, 1'h0};

    // control pins; clear held asserted and outputs disabled out of reset
    ssld_sync #(
        .WIDTH     (3),
        .RESET_VAL (CTRL_RESET)
    ) u_ctrl_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({storage_clock, output_enable_n, clear_n}),
        .sync_out ({store_clk_s, oe_s_n, clear_s_n})
    );

    // shift contents as quasi-static levels; stable once shifting stops
    // limitation: a shift edge between storage edge and capture tears the word
    ssld_sync #(
        .WIDTH     (CHANNELS),
        .RESET_VAL (ssld_pkg::SHIFT_RESET)
    ) u_word_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (shift_reg),
        .sync_out (word_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // storage clock edge and word settling
    ////////////////////////////////////////////////////////////////////////

    localparam int unsigned QW = $clog2(ssld_pkg::SETTLE_CYCLES + 1);

    logic                store_clk_d;
    logic                next_store_clk_d;
    logic                store_rise;
    logic [CHANNELS-1:0] word_d;
    logic [CHANNELS-1:0] next_word_d;
    logic [QW-1:0]       quiet_cnt;
    logic [QW-1:0]       next_quiet_cnt;
    logic                word_settled;

    // rising edge of the synchronised storage clock
    assign store_rise = store_clk_s & ~store_clk_d;

    // delay starts low like the idle pin, so reset makes no false edge
    always_comb begin
        next_store_clk_d = store_clk_s;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            store_clk_d <= 1'h0;
        end else begin
            store_clk_d <= next_store_clk_d;
        end
    end

    // bits of the word may arrive in different cycles; wait until all agree
    assign word_settled = (quiet_cnt == QW'(ssld_pkg::SETTLE_CYCLES));

    // count restarts on any change and saturates once settled
    always_comb begin
        next_word_d = word_s;
        if (word_s != word_d) begin
            next_quiet_cnt = '0;
        end else if (!word_settled) begin
            next_quiet_cnt = quiet_cnt + QW'(1);
        end else begin
            next_quiet_cnt = quiet_cnt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_d    <= ssld_pkg::SHIFT_RESET;
            quiet_cnt <= '0;
        end else begin
            word_d    <= next_word_d;
            quiet_cnt <= next_quiet_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture sequence: edge, settle, push into buffer
    ////////////////////////////////////////////////////////////////////////

    ssld_pkg::ssld_cap_state_t cap_state;
    ssld_pkg::ssld_cap_state_t next_cap_state;
    logic [CHANNELS-1:0]       cap_word;
    logic [CHANNELS-1:0]       next_cap_word;
    logic                      buf_in_ready;
    logic                      buf_out_valid;
    logic [CHANNELS-1:0]       buf_out_data;
    logic                      buf_flush;
    logic                      cap_push;

    // a storage edge during settle is folded into the one pending; during push it is dropped
    always_comb begin
        next_cap_state = cap_state;
        next_cap_word  = cap_word;
        if (!clear_s_n) begin
            next_cap_state = ssld_pkg::SSLD_IDLE;
            next_cap_word  = ssld_pkg::STORE_RESET;
        end else begin
            unique case (cap_state)
                ssld_pkg::SSLD_IDLE: begin
                    if (store_rise) begin
                        next_cap_state = ssld_pkg::SSLD_SETTLE;
                    end
                end
                ssld_pkg::SSLD_SETTLE: begin
                    if (word_settled) begin
                        next_cap_word  = word_d;
                        next_cap_state = ssld_pkg::SSLD_PUSH;
                    end
                end
                ssld_pkg::SSLD_PUSH: begin
                    // a full buffer stalls here instead of losing the word
                    if (buf_in_ready) begin
                        next_cap_state = ssld_pkg::SSLD_IDLE;
                    end
                end
                default: begin
                    next_cap_state = ssld_pkg::SSLD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_state <= ssld_pkg::SSLD_IDLE;
            cap_word  <= ssld_pkg::STORE_RESET;
        end else begin
            cap_state <= next_cap_state;
            cap_word  <= next_cap_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer between capture and storage register
    ////////////////////////////////////////////////////////////////////////

    logic store_ready;

    // drain stalls while clear is low, flush then empties it
    assign buf_flush   = ~clear_s_n;
    assign store_ready = clear_s_n;

    // request to the buffer for as long as a captured word waits
    assign cap_push    = (cap_state == ssld_pkg::SSLD_PUSH);

    ssld_buf2 #(
        .WIDTH (CHANNELS),
        .DEPTH (ssld_pkg::BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .rstn      (rstn),
        .flush     (buf_flush),
        .in_valid  (cap_push),
        .in_ready  (buf_in_ready),
        .in_data   (cap_word),
        .out_valid (buf_out_valid),
        .out_ready (store_ready),
        .out_data  (buf_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // storage register
    ////////////////////////////////////////////////////////////////////////

    logic [CHANNELS-1:0] store_reg;
    logic [CHANNELS-1:0] next_store_reg;

    // full-width copy per storage edge, cleared with everything else
    always_comb begin
        next_store_reg = store_reg;
        if (!clear_s_n) begin
            next_store_reg = ssld_pkg::STORE_RESET;
        end else if (buf_out_valid && store_ready) begin
            next_store_reg = buf_out_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            store_reg <= ssld_pkg::STORE_RESET;
        end else begin
            store_reg <= next_store_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffer and open-drain channels
    ////////////////////////////////////////////////////////////////////////

    logic [CHANNELS-1:0] out_buf;
    logic [CHANNELS-1:0] next_out_buf;

    // enable gates storage onto the channels; clear blocks the path too
    always_comb begin
        if (oe_s_n || !clear_s_n) begin
            next_out_buf = ssld_pkg::CHANNEL_RESET;
        end else begin
            next_out_buf = store_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_buf <= ssld_pkg::CHANNEL_RESET;
        end else begin
            out_buf <= next_out_buf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain pin drivers, registered per channel
    ////////////////////////////////////////////////////////////////////////

    logic [CHANNELS-1:0] sink_level;
    logic [CHANNELS-1:0] sink_oe_n;

    // own flops per pin, so no gate sits between flop and pad
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_pin
        logic next_level;
        logic next_oe_n;

        // drain only ever pulled low; enable low while sinking
        always_comb begin
            next_level = ssld_pkg::CHANNEL_RESET[ch];
            next_oe_n  = ~next_out_buf[ch];
        end

        // same cycle as out_buf, so channel and enable never disagree
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                sink_level[ch] <= ssld_pkg::CHANNEL_RESET[ch];
                sink_oe_n[ch]  <= ~ssld_pkg::CHANNEL_RESET[ch];
            end else begin
                sink_level[ch] <= next_level;
                sink_oe_n[ch]  <= next_oe_n;
            end
        end
    end

    // ports straight from the flops
    assign channel_sink      = out_buf;
    assign channel_sink_out  = sink_level;
    assign channel_sink_oe_n = sink_oe_n;

endmodule

//--- tb/ssld_top_chk.sv
// concurrent checks on the ports of the serial shift latch driver
`timescale 1ns/1ps
module ssld_top_chk #(
    parameter int unsigned CHANNELS = 8
) (
    input wire logic                clk,
    input wire logic                rstn,
    input wire logic                shift_clock,
    input wire logic                serial_in,
    input wire logic                storage_clock,
    input wire logic                clear_n,
    input wire logic                output_enable_n,
    input wire logic                cascade_out,
    input wire logic [CHANNELS-1:0] channel_sink,
    input wire logic [CHANNELS-1:0] channel_sink_out,
    input wire logic [CHANNELS-1:0] channel_sink_oe_n
);
    logic                link_rstn;
    logic                quiet;
    logic                prev_store;
    logic                prev_last;
    logic [CHANNELS-1:0] mirror;
    logic [CHANNELS-1:0] cap;
    logic [CHANNELS-1:0] next_mirror;
    logic [CHANNELS-1:0] next_cap;

    // reference stages; the shift side is still at a storage edge, so no sync
    assign link_rstn   = rstn & clear_n;
    assign next_mirror = {mirror[CHANNELS-2:0], serial_in};
    assign next_cap    = (storage_clock && !prev_store) ? mirror : cap;
    assign quiet       = !storage_clock && clear_n && !output_enable_n;

    // link copy, plus the last stage as it stood before each shift
    always_ff @(posedge shift_clock or negedge link_rstn) begin
        if (!link_rstn) begin
            mirror    <= '0;
            prev_last <= 1'b0;
        end else begin
            mirror    <= next_mirror;
            prev_last <= mirror[CHANNELS-1];
        end
    end

    // word expected after each storage edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_store <= 1'b0;
            cap        <= '0;
        end else begin
            prev_store <= storage_clock;
            cap        <= next_cap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    cascade_data_a: assert property (@(posedge shift_clock) disable iff (!link_rstn)
        cascade_out == mirror[CHANNELS-1]) else $error("cascade not last stage");
    cascade_fall_a: assert property (@(negedge shift_clock) disable iff (!link_rstn)
        cascade_out == prev_last) else $error("cascade moved off falling edge");
    store_word_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(storage_clock) && clear_n && !output_enable_n |-> ##[5:10] channel_sink == cap)
        else $error("stored word missing on channels");
    hold_still_a: assert property (@(posedge clk) disable iff (!rstn)
        quiet [*8] ##1 quiet [*4] |-> $stable(channel_sink)) else $error("channels moved");
    oe_off_a: assert property (@(posedge clk) disable iff (!rstn)
        output_enable_n [*4] |-> channel_sink == '0) else $error("channels on while disabled");
    clear_off_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(clear_n) |-> ##[1:4] channel_sink == '0) else $error("clear left channels on");
    pin_level_a: assert property (@(posedge clk) disable iff (!rstn)
        channel_sink_out == '0) else $error("open drain value not low");
    pin_enable_a: assert property (@(posedge clk) disable iff (!rstn)
        channel_sink_oe_n == ~channel_sink) else $error("pin enable not inverse of channel");
endmodule

bind ssld_top ssld_top_chk #(.CHANNELS(CHANNELS)) u_chk (
    .clk(clk), .rstn(rstn), .shift_clock(shift_clock), .serial_in(serial_in),
    .storage_clock(storage_clock), .clear_n(clear_n), .output_enable_n(output_enable_n),
    .cascade_out(cascade_out), .channel_sink(channel_sink),
    .channel_sink_out(channel_sink_out), .channel_sink_oe_n(channel_sink_oe_n)
);

//--- tb/ssld_host.sv
// host controller model: drives the link and storage pins
`timescale 1ns/1ps
module ssld_host (
    output logic shift_clock,
    output logic serial_in,
    output logic storage_clock
);
    // pins idle low; the link clock only runs inside a frame
    initial begin
        shift_clock   = 1'b0;
        serial_in     = 1'b0;
        storage_clock = 1'b0;
    end

    // one frame at a 12 ns link period, first bit ends in the last stage;
    // gap stretches the pause between bits, start phase drifts against clk
    task automatic send(input logic [7:0] w, input int gap);
        #(1 + ($urandom % 11));
        for (int i = 7; i >= 0; i--) begin
            serial_in = w[i];
            #6 shift_clock = 1'b1;
            #6 shift_clock = 1'b0;
            #(gap);
        end
        // hold has run out: show the inverse so a stale bit cannot pass
        #6 serial_in = ~w[0];
    endtask

    // storage pulse of three system cycles, link kept still around it
    task automatic store();
        storage_clock = 1'b1;
        #300 storage_clock = 1'b0;
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench of the serial shift latch driver
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb_top;
    logic       clk;
    logic       rstn;
    logic       clear_n;
    logic       output_enable_n;
    logic       shift_clock;
    logic       serial_in;
    logic       storage_clock;
    logic       cascade_out;
    logic [7:0] channel_sink;
    logic [7:0] channel_sink_out;
    logic [7:0] channel_sink_oe_n;
    logic [7:0] word;
    logic [7:0] corner [4];
    int         errors;
    int         cmp_count;

    ssld_top dut (.clk(clk), .rstn(rstn), .shift_clock(shift_clock), .serial_in(serial_in),
        .storage_clock(storage_clock), .clear_n(clear_n), .output_enable_n(output_enable_n),
        .cascade_out(cascade_out), .channel_sink(channel_sink),
        .channel_sink_out(channel_sink_out), .channel_sink_oe_n(channel_sink_oe_n));
    ssld_host host (.shift_clock(shift_clock), .serial_in(serial_in),
        .storage_clock(storage_clock));

    // 10 MHz system clock
    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // channels expected from a stored word under the present gating
    function automatic logic [7:0] expect_ch(input logic [7:0] w);
        return (clear_n && !output_enable_n) ? w : 8'h00;
    endfunction

    task automatic check_pins(input logic [7:0] w);
        `CHK(channel_sink, expect_ch(w))
        `CHK(channel_sink_oe_n, ~expect_ch(w))
        `CHK(channel_sink_out, 8'h00)
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // shift a frame, then pulse storage and let the sync chain settle
    task automatic load(input logic [7:0] w, input int half);
        host.send(w, half);
        wait_clk(1);
        host.store();
        wait_clk(12);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // the whole run is near 55 us; over three times that means a hang
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        clear_n = 1'b1;
        output_enable_n = 1'b0;
        errors = 0;
        cmp_count = 0;
        corner = '{8'h80, 8'h01, 8'hFF, 8'h00};
        word = 8'($urandom(32'h0EF055A2));
        wait_clk(16);
        check_pins(8'h00);
        `CHK(cascade_out, 1'b0)
        rstn = 1'b1;
        wait_clk(4);
        for (int i = 0; i < 24; i++) begin
            word = (i < 4) ? corner[i] : 8'($urandom);
            load(word, (i % 3 == 0) ? 48 : 0);
            check_pins(word);
            `CHK(cascade_out, word[7])
        end
        $display("test words done");
        output_enable_n = 1'b1;
        wait_clk(4);
        check_pins(word);
        host.send(~word, 6);
        wait_clk(12);
        `CHK(cascade_out, ~word[7])
        output_enable_n = 1'b0;
        wait_clk(4);
        check_pins(word);
        $display("test enable done");
        clear_n = 1'b0;
        wait_clk(4);
        check_pins(word);
        `CHK(cascade_out, 1'b0)
        host.send(8'hA5, 6);
        load(8'h5A, 6);
        clear_n = 1'b1;
        wait_clk(4);
        check_pins(8'h00);
        host.store();
        wait_clk(12);
        check_pins(8'h00);
        $display("test clear done");
        load(8'($urandom), 6);
        rstn = 1'b0;
        wait_clk(2);
        check_pins(8'h00);
        `CHK(cascade_out, 1'b0)
        rstn = 1'b1;
        wait_clk(4);
        host.store();
        wait_clk(12);
        check_pins(8'h00);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
